// [rtl/xse_pkg.sv]
// Package with constants for the exception stack entry and return sequencer
//
// Function
// - Push to process stack in Thread mode with stack select set, else main.
// - Decrement the selected stack pointer before writing any frame word.
// - Read all frame words first, then increment the stack pointer.
// - Frame holds eight words: status, return address, link, R12, R3-R0.
// - New pointer is old minus 0x20 with bit 2 cleared; old bit 2 kept.
// - Frame layout R0 at 0 up to status at 0x1c, order free.
// - Stacked status carries live bits with bit 9 holding realignment flag.
// - Link gets return code by entry mode and stack select.
// - Enter Handler mode, load exception number, clear stack select, keep privilege.
// - Set active flag, update status, set event, barrier before handler fetch.
// - Handler address read from vector base plus four times exception number.
// - Return address chosen by exception cause: faulting, next, or after call.
// - Stacked return address has bit 0 forced to zero.
// - Escalated supervisor call stacks the supervisor call return address.
// - Return only in Handler mode on pop or register branch with top nibble ones.
// - Return code has top nibble ones; software keeps bits 27 to 4 ones.
// - Low nibble selects Handler-main, Thread-main or Thread-process return.
// - Return codes outside valid return paths are ordinary execute-never addresses.
// - Popped status bit 9 set re-adds the padding word to the pointer.
// - Valid return clears active flag; stack select set only for Thread-process.
package xse_pkg;
  localparam int unsigned XSE_FRAME_WORDS = 8;
  localparam logic [31:0] XSE_FRAME_BYTES = 32'h0000_0020;
  localparam logic [31:0] XSE_ALIGN_MASK = 32'h0000_0004;
  localparam int unsigned XSE_ALIGN_BIT = 2;
  localparam int unsigned XSE_PSR_ALIGN_BIT = 9;
  localparam logic [31:0] XSE_RET_HANDLER = 32'hffff_fff1;
  localparam logic [31:0] XSE_RET_THR_MAIN = 32'hffff_fff9;
  localparam logic [31:0] XSE_RET_THR_PROC = 32'hffff_fffd;
  localparam logic [3:0] XSE_RET_TOP = 4'hf;
  localparam logic [3:0] XSE_NIB_HANDLER = 4'h1;
  localparam logic [3:0] XSE_NIB_THR_MAIN = 4'h9;
  localparam logic [3:0] XSE_NIB_THR_PROC = 4'hd;
  localparam int unsigned XSE_EXC_W = 6;
  localparam int unsigned XSE_NUM_EXC = 64;
  // Frame word index (offset / 4)
  localparam logic [2:0] XSE_IDX_R0 = 3'h0;
  localparam logic [2:0] XSE_IDX_R1 = 3'h1;
  localparam logic [2:0] XSE_IDX_R2 = 3'h2;
  localparam logic [2:0] XSE_IDX_R3 = 3'h3;
  localparam logic [2:0] XSE_IDX_R12 = 3'h4;
  localparam logic [2:0] XSE_IDX_LR = 3'h5;
  localparam logic [2:0] XSE_IDX_PC = 3'h6;
  localparam logic [2:0] XSE_IDX_PSR = 3'h7;
  // Exception cause for return address selection
  typedef enum logic [1:0] {
    XSE_CAUSE_ASYNC = 2'b00,
    XSE_CAUSE_PRECISE = 2'b01,
    XSE_CAUSE_SVC = 2'b10,
    XSE_CAUSE_SVC_ESC = 2'b11
  } xse_cause_t;
  typedef enum logic [2:0] {
    XSE_IDLE = 3'b000,
    XSE_PUSH = 3'b001,
    XSE_VEC = 3'b010,
    XSE_POP = 3'b011,
    XSE_DONE = 3'b100
  } xse_state_t;
endpackage

// [rtl/xse_frame_addr.sv]
// Frame word address and alignment helper
`timescale 1ns/100ps
module xse_frame_addr
  import xse_pkg::*;
(
  input wire logic [31:0] old_sp,
  input wire logic [31:0] frame_sp,
  input wire logic [2:0] idx,
  input wire logic pad_flag,
  output logic [31:0] push_sp,
  output logic align_flag,
  output logic [31:0] word_addr,
  output logic [31:0] pop_sp
);
  always_comb begin
    push_sp = (old_sp - XSE_FRAME_BYTES) & ~XSE_ALIGN_MASK;
    align_flag = old_sp[XSE_ALIGN_BIT];
    word_addr = {frame_sp[31:2] + {27'h0, idx}, 2'b00};
    pop_sp = (frame_sp + XSE_FRAME_BYTES) | (pad_flag ? XSE_ALIGN_MASK : 32'h0);
  end
endmodule

// [rtl/xse_seq.sv]
// Exception entry and return sequencer
`timescale 1ns/100ps
module xse_seq
  import xse_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic exc_req,
  input wire logic [xse_pkg::XSE_EXC_W-1:0] exc_num,
  input wire xse_pkg::xse_cause_t exc_cause,
  input wire logic [31:0] fault_pc,
  input wire logic [31:0] next_pc,
  input wire logic [31:0] vector_base,
  input wire logic [31:0] live_psr,
  input wire logic [31:0] reg_r0,
  input wire logic [31:0] reg_r1,
  input wire logic [31:0] reg_r2,
  input wire logic [31:0] reg_r3,
  input wire logic [31:0] reg_r12,
  input wire logic [31:0] link_register,
  input wire logic pc_write,
  input wire logic pc_write_ret_kind,
  input wire logic [31:0] pc_write_value,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [1:0] mem_size,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [31:0] mem_rdata,
  output logic [31:0] main_stack_pointer,
  output logic [31:0] process_stack_pointer,
  output logic handler_mode,
  output logic stack_select_bit,
  output logic unprivileged_thread_bit,
  input wire logic unpriv_set,
  input wire logic unpriv_val,
  output logic [xse_pkg::XSE_EXC_W-1:0] exception_number_field,
  output logic [xse_pkg::XSE_NUM_EXC-1:0] exc_active,
  output logic status_update,
  output logic event_set,
  output logic isb_pulse,
  output logic branch_valid,
  output logic [31:0] branch_addr,
  output logic [31:0] link_out,
  output logic link_write,
  output logic [31:0] pop_data,
  output logic [2:0] pop_idx,
  output logic pop_valid,
  output logic access_fault,
  output logic xn_fault,
  output logic busy
);
  xse_state_t st_q, st_d;
  logic [2:0] idx_q, idx_d;
  logic [31:0] msp_q, msp_d, psp_q, psp_d, fsp_q, fsp_d;
  logic handler_q, handler_d, sel_q, sel_d, unprivileged_thread_bit_q, unprivileged_thread_bit_d;
  logic [XSE_EXC_W-1:0] excn_q, excn_d;
  logic [XSE_NUM_EXC-1:0] act_q, act_d;
  logic [31:0] frame_q [XSE_FRAME_WORDS];
  logic [31:0] frame_d [XSE_FRAME_WORDS];
  logic [3:0] nib_q, nib_d;
  logic use_psp_q, use_psp_d;
  logic [31:0] br_q, br_d, lk_q, lk_d, pd_q, pd_d;
  logic brv_q, brv_d, lkw_q, lkw_d, pv_q, pv_d, af_q, af_d, xn_q, xn_d;
  logic su_q, su_d, ev_q, ev_d, isb_q, isb_d;
  logic [2:0] pi_q, pi_d;
  logic [31:0] old_sp, push_sp, word_addr, pop_sp, ret_addr;
  logic align_flag, push_psp, ret_hit;

  assign push_psp = sel_q && !handler_q;
  assign old_sp = push_psp ? psp_q : msp_q;
  assign ret_hit = pc_write && pc_write_value[31:28] == XSE_RET_TOP;

  xse_frame_addr u_addr (
    .old_sp(old_sp),
    .frame_sp(fsp_q),
    .idx(idx_q),
    .pad_flag(mem_rdata[XSE_PSR_ALIGN_BIT]),
    .push_sp(push_sp),
    .align_flag(align_flag),
    .word_addr(word_addr),
    .pop_sp(pop_sp)
  );

  always_comb begin
    // Return address by cause, halfword aligned
    case (exc_cause)
      XSE_CAUSE_PRECISE: ret_addr = fault_pc;
      XSE_CAUSE_SVC, XSE_CAUSE_SVC_ESC: ret_addr = next_pc;
      default: ret_addr = next_pc;
    endcase
    ret_addr[0] = 1'b0;
  end

  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    msp_d = msp_q;
    psp_d = psp_q;
    fsp_d = fsp_q;
    handler_d = handler_q;
    sel_d = sel_q;
    unprivileged_thread_bit_d = unpriv_set ? unpriv_val : unprivileged_thread_bit_q;
    excn_d = excn_q;
    act_d = act_q;
    frame_d = frame_q;
    nib_d = nib_q;
    use_psp_d = use_psp_q;
    br_d = br_q;
    lk_d = lk_q;
    pd_d = pd_q;
    pi_d = pi_q;
    brv_d = 1'b0;
    lkw_d = 1'b0;
    pv_d = 1'b0;
    af_d = 1'b0;
    xn_d = 1'b0;
    su_d = 1'b0;
    ev_d = 1'b0;
    isb_d = 1'b0;
    case (st_q)
      XSE_IDLE: begin
        if (exc_req) begin
          if (push_psp) begin
            psp_d = push_sp;
          end else begin
            msp_d = push_sp;
          end
          fsp_d = push_sp;
          frame_d[XSE_IDX_R0] = reg_r0;
          frame_d[XSE_IDX_R1] = reg_r1;
          frame_d[XSE_IDX_R2] = reg_r2;
          frame_d[XSE_IDX_R3] = reg_r3;
          frame_d[XSE_IDX_R12] = reg_r12;
          frame_d[XSE_IDX_LR] = link_register;
          frame_d[XSE_IDX_PC] = ret_addr;
          frame_d[XSE_IDX_PSR] = {live_psr[31:10], align_flag, live_psr[8:0]};
          if (handler_q) begin
            lk_d = XSE_RET_HANDLER;
          end else if (!sel_q) begin
            lk_d = XSE_RET_THR_MAIN;
          end else begin
            lk_d = XSE_RET_THR_PROC;
          end
          excn_d = exc_num;
          idx_d = 3'h0;
          st_d = XSE_PUSH;
        end else if (ret_hit) begin
          if (handler_q && pc_write_ret_kind &&
              (pc_write_value[3:0] == XSE_NIB_HANDLER ||
               pc_write_value[3:0] == XSE_NIB_THR_MAIN ||
               pc_write_value[3:0] == XSE_NIB_THR_PROC)) begin
            nib_d = pc_write_value[3:0];
            use_psp_d = pc_write_value[3:0] == XSE_NIB_THR_PROC;
            fsp_d = (pc_write_value[3:0] == XSE_NIB_THR_PROC) ? psp_q : msp_q;
            idx_d = 3'h0;
            st_d = XSE_POP;
          end else begin
            xn_d = 1'b1;
          end
        end
      end
      XSE_PUSH: begin
        if (mem_ack) begin
          af_d = mem_err;
          if (idx_q == XSE_IDX_PSR) begin
            lkw_d = 1'b1;
            handler_d = 1'b1;
            sel_d = 1'b0;
            act_d[excn_q] = 1'b1;
            su_d = 1'b1;
            ev_d = 1'b1;
            isb_d = 1'b1;
            st_d = XSE_VEC;
          end else begin
            idx_d = idx_q + 3'h1;
          end
        end
      end
      XSE_VEC: begin
        if (mem_ack) begin
          af_d = mem_err;
          br_d = mem_rdata;
          brv_d = 1'b1;
          st_d = XSE_IDLE;
        end
      end
      XSE_POP: begin
        if (mem_ack) begin
          af_d = mem_err;
          pd_d = mem_rdata;
          pi_d = idx_q;
          pv_d = 1'b1;
          if (idx_q == XSE_IDX_PC) begin
            br_d = mem_rdata;
          end
          if (idx_q == XSE_IDX_PSR) begin
            if (use_psp_q) begin
              psp_d = pop_sp;
            end else begin
              msp_d = pop_sp;
            end
            act_d[excn_q] = 1'b0;
            sel_d = use_psp_q;
            handler_d = nib_q == XSE_NIB_HANDLER;
            excn_d = (nib_q != XSE_NIB_HANDLER && unprivileged_thread_bit_q) ? '0 : mem_rdata[5:0];
            st_d = XSE_DONE;
          end else begin
            idx_d = idx_q + 3'h1;
          end
        end
      end
      XSE_DONE: begin
        ev_d = 1'b1;
        isb_d = 1'b1;
        brv_d = 1'b1;
        st_d = XSE_IDLE;
      end
      default: st_d = XSE_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= XSE_IDLE;
      idx_q <= 3'h0;
      msp_q <= 32'h0;
      psp_q <= 32'h0;
      fsp_q <= 32'h0;
      handler_q <= 1'b0;
      sel_q <= 1'b0;
      unprivileged_thread_bit_q <= 1'b0;
      excn_q <= '0;
      act_q <= '0;
      for (int i = 0; i < XSE_FRAME_WORDS; i++) begin
        frame_q[i] <= 32'h0;
      end
      nib_q <= 4'h0;
      use_psp_q <= 1'b0;
      br_q <= 32'h0;
      lk_q <= 32'h0;
      pd_q <= 32'h0;
      pi_q <= 3'h0;
      brv_q <= 1'b0;
      lkw_q <= 1'b0;
      pv_q <= 1'b0;
      af_q <= 1'b0;
      xn_q <= 1'b0;
      su_q <= 1'b0;
      ev_q <= 1'b0;
      isb_q <= 1'b0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      msp_q <= msp_d;
      psp_q <= psp_d;
      fsp_q <= fsp_d;
      handler_q <= handler_d;
      sel_q <= sel_d;
      unprivileged_thread_bit_q <= unprivileged_thread_bit_d;
      excn_q <= excn_d;
      act_q <= act_d;
      frame_q <= frame_d;
      nib_q <= nib_d;
      use_psp_q <= use_psp_d;
      br_q <= br_d;
      lk_q <= lk_d;
      pd_q <= pd_d;
      pi_q <= pi_d;
      brv_q <= brv_d;
      lkw_q <= lkw_d;
      pv_q <= pv_d;
      af_q <= af_d;
      xn_q <= xn_d;
      su_q <= su_d;
      ev_q <= ev_d;
      isb_q <= isb_d;
    end
  end

  // Memory port, word accesses only
  always_comb begin
    mem_req = st_q == XSE_PUSH || st_q == XSE_VEC || st_q == XSE_POP;
    mem_we = st_q == XSE_PUSH;
    mem_size = 2'b10;
    mem_wdata = frame_q[idx_q];
    if (st_q == XSE_VEC) begin
      mem_addr = {vector_base[31:2] + {24'h0, excn_q}, 2'b00};
    end else begin
      mem_addr = word_addr;
    end
  end

  assign main_stack_pointer = msp_q;
  assign process_stack_pointer = psp_q;
  assign handler_mode = handler_q;
  assign stack_select_bit = sel_q;
  assign unprivileged_thread_bit = unprivileged_thread_bit_q;
  assign exception_number_field = excn_q;
  assign exc_active = act_q;
  assign status_update = su_q;
  assign event_set = ev_q;
  assign isb_pulse = isb_q;
  assign branch_valid = brv_q;
  assign branch_addr = br_q;
  assign link_out = lk_q;
  assign link_write = lkw_q;
  assign pop_data = pd_q;
  assign pop_idx = pi_q;
  assign pop_valid = pv_q;
  assign access_fault = af_q;
  assign xn_fault = xn_q;
  assign busy = st_q != XSE_IDLE;
endmodule

// [bench/xse_mem_model.sv]
// Memory model holding stack frames and the vector table
`timescale 1ns/100ps
module xse_mem_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:127];
  logic [1:0] wait_q;
  // Plain always so the bench can preload words
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!rst_n) begin
      wait_q <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack) begin
      if (wait_q == {slow, 1'b0}) begin
        wait_q <= 2'h0;
        mem_ack <= 1'b1;
        if (mem_we) mem[mem_addr[8:2]] <= mem_wdata;
        else mem_rdata <= mem[mem_addr[8:2]];
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule

// [bench/xse_seq_chk.sv]
// Port assertions for the exception sequencer
`timescale 1ns/100ps
module xse_seq_chk
  import xse_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic exc_req,
  input wire logic pc_write,
  input wire logic [31:0] pc_write_value,
  input wire logic [31:0] vector_base,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] main_stack_pointer,
  input wire logic [31:0] process_stack_pointer,
  input wire logic handler_mode,
  input wire logic stack_select_bit,
  input wire logic [5:0] exception_number_field,
  input wire logic status_update,
  input wire logic event_set,
  input wire logic isb_pulse,
  input wire logic [31:0] link_out,
  input wire logic link_write,
  input wire logic xn_fault,
  input wire logic busy
);
  logic [31:0] sel_sp;
  logic [31:0] off;
  assign sel_sp = (stack_select_bit && !handler_mode) ? process_stack_pointer : main_stack_pointer;
  assign off = mem_addr - sel_sp;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_word;
    mem_req |-> mem_size == 2'b10 && mem_addr[1:0] == 2'b00;
  endproperty
  a_word: assert property (p_word) else $error("non-word access");
  property p_frame;
    mem_req && mem_we |-> off < 32'h20;
  endproperty
  a_frame: assert property (p_frame) else $error("write outside frame");
  property p_pc_even;
    mem_req && mem_we && off == 32'h18 |-> !mem_wdata[0];
  endproperty
  a_pc_even: assert property (p_pc_even) else $error("odd return address");
  property p_main_dec;
    exc_req && !busy && !(stack_select_bit && !handler_mode) |=>
      main_stack_pointer == (($past(main_stack_pointer) - 32'h20) & ~32'h4);
  endproperty
  a_main_dec: assert property (p_main_dec) else $error("main pointer wrong");
  property p_proc_dec;
    exc_req && !busy && stack_select_bit && !handler_mode |=> $stable(main_stack_pointer) &&
      process_stack_pointer == (($past(process_stack_pointer) - 32'h20) & ~32'h4);
  endproperty
  a_proc_dec: assert property (p_proc_dec) else $error("process pointer wrong");
  property p_link;
    link_write |-> link_out == ($past(handler_mode) ? XSE_RET_HANDLER :
      $past(stack_select_bit) ? XSE_RET_THR_PROC : XSE_RET_THR_MAIN);
  endproperty
  a_link: assert property (p_link) else $error("wrong return code");
  property p_taken;
    link_write |-> handler_mode && !stack_select_bit && status_update && event_set && isb_pulse;
  endproperty
  a_taken: assert property (p_taken) else $error("handler state wrong");
  property p_vec;
    link_write |-> mem_req && !mem_we &&
      mem_addr == vector_base + {24'h0, exception_number_field, 2'b00};
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_xn;
    pc_write && pc_write_value[31:28] == 4'hf && !handler_mode && !busy && !exc_req |=>
      xn_fault && !busy;
  endproperty
  a_xn: assert property (p_xn) else $error("no execute-never fault");
  c_entry: cover property (link_write);
  c_xn: cover property (xn_fault);
  c_thread: cover property ($fell(handler_mode));
endmodule
bind xse_seq xse_seq_chk u_chk (.*);

// [bench/testbench.sv]
// Self-checking bench for the exception sequencer
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module testbench;
  import xse_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, exc_req = 1'b0, pc_write = 1'b0, pc_write_ret_kind = 1'b1;
  logic mem_err = 1'b0, unpriv_set = 1'b0, unpriv_val = 1'b0, slow = 1'b0, mem_ack;
  logic [5:0] exc_num = 6'h0;
  xse_cause_t exc_cause = XSE_CAUSE_ASYNC;
  logic [31:0] fault_pc = 32'h4444, next_pc = 32'h1235, vector_base = 32'h100;
  logic [31:0] live_psr = 32'h6100_0200, reg_r0 = 32'ha0, reg_r1 = 32'ha1, reg_r2 = 32'ha2;
  logic [31:0] reg_r3 = 32'ha3, reg_r12 = 32'hac, link_register = 32'h1e, pc_write_value = 32'h0;
  logic mem_req, mem_we, handler_mode, stack_select_bit, unprivileged_thread_bit, status_update;
  logic event_set, isb_pulse, branch_valid, link_write, pop_valid, access_fault, xn_fault, busy;
  logic [1:0] mem_size;
  logic [2:0] pop_idx;
  logic [5:0] exception_number_field;
  logic [63:0] exc_active;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, main_stack_pointer, process_stack_pointer;
  logic [31:0] branch_addr, link_out, pop_data, lnk, br;
  logic [31:0] popw [8];
  int num_errors = 0, checks_done = 0, xn = 0, cyc = 0, afs = 0;
  xse_seq u_dut (.*);
  xse_mem_model u_mem (.*);
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    if (link_write) lnk = link_out;
    if (branch_valid) br = branch_addr;
    if (xn_fault) xn++;
    if (access_fault) afs++;
    if (pop_valid) popw[pop_idx] = pop_data;
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_idle();
    int n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    `CHK("idle", 1'b0, busy)
    repeat (3) @(negedge mclk);
  endtask
  task automatic take_exc(input logic [5:0] num, input xse_cause_t c);
    exc_num = num;
    exc_cause = c;
    exc_req = 1'b1;
    @(negedge mclk);
    exc_req = 1'b0;
    wait_idle();
  endtask
  task automatic do_ret(input logic [31:0] code);
    pc_write_value = code;
    pc_write = 1'b1;
    @(negedge mclk);
    pc_write = 1'b0;
    wait_idle();
  endtask
  task automatic chk_frame(input logic [6:0] b, input logic [31:0] pc, input logic [31:0] psr);
    logic [31:0] f [8];
    f = '{reg_r0, reg_r1, reg_r2, reg_r3, reg_r12, link_register, pc, psr};
    for (int i = 0; i < 8; i++) `CHK("frame word", f[i], u_mem.mem[7'(b + i)])
  endtask
  task automatic t_entry_main();
    u_mem.mem[7'h4b] = 32'h801;
    take_exc(6'd11, XSE_CAUSE_SVC_ESC);
    `CHK("main sp", 32'hffffffe0, main_stack_pointer)
    chk_frame(7'h78, 32'h1234, 32'h6100_0000);
    `CHK("link", XSE_RET_THR_MAIN, lnk)
    `CHK("state", 3'b101, {handler_mode, stack_select_bit, exc_active[11]})
    `CHK("number", 6'd11, exception_number_field)
    `CHK("handler", 32'h801, br)
  endtask
  task automatic t_ret_proc();
    for (int i = 0; i < 8; i++) u_mem.mem[i] = 32'h55 + i;
    u_mem.mem[6] = 32'h2000;
    u_mem.mem[7] = 32'h200;
    do_ret(XSE_RET_THR_PROC);
    `CHK("proc sp", 32'h24, process_stack_pointer)
    `CHK("state", 3'b010, {handler_mode, stack_select_bit, exc_active[11]})
    `CHK("resume", 32'h2000, br)
    `CHK("pop r1", 32'h56, popw[1])
    `CHK("pop psr", 32'h200, popw[7])
  endtask
  task automatic t_entry_proc();
    slow = 1'b1;
    live_psr = 32'h3;
    fault_pc = 32'h3003;
    u_mem.mem[7'h43] = 32'h901;
    take_exc(6'd3, XSE_CAUSE_PRECISE);
    `CHK("proc sp", 32'h0, process_stack_pointer)
    `CHK("main sp", 32'hffffffe0, main_stack_pointer)
    chk_frame(7'h0, 32'h3002, 32'h203);
    `CHK("link", XSE_RET_THR_PROC, lnk)
    `CHK("sel", 1'b0, stack_select_bit)
    `CHK("handler", 32'h901, br)
  endtask
  task automatic t_nested();
    u_mem.mem[7'h42] = 32'hb01;
    take_exc(6'd2, XSE_CAUSE_ASYNC);
    `CHK("main sp", 32'hffffffc0, main_stack_pointer)
    `CHK("link", XSE_RET_HANDLER, lnk)
    do_ret(XSE_RET_HANDLER);
    `CHK("main sp", 32'hffffffe0, main_stack_pointer)
    `CHK("mode", 1'b1, handler_mode)
    `CHK("number", 6'd3, exception_number_field)
    `CHK("active", 1'b0, exc_active[2])
    `CHK("resume", 32'h1234, br)
  endtask
  task automatic t_ret_main();
    do_ret(XSE_RET_THR_MAIN);
    `CHK("main sp", 32'h0, main_stack_pointer)
    `CHK("state", 3'b000, {handler_mode, stack_select_bit, exc_active[3]})
    `CHK("resume", 32'h1234, br)
  endtask
  task automatic t_thread_code();
    do_ret(XSE_RET_THR_MAIN);
    `CHK("xn count", 1, xn)
    `CHK("main sp", 32'h0, main_stack_pointer)
  endtask
  task automatic t_fault_unpriv();
    unpriv_set = 1'b1;
    unpriv_val = 1'b1;
    @(negedge mclk);
    unpriv_set = 1'b0;
    mem_err = 1'b1;
    u_mem.mem[7'h44] = 32'hc01;
    take_exc(6'd4, XSE_CAUSE_SVC);
    mem_err = 1'b0;
    `CHK("faults", 9, afs)
    `CHK("unpriv", 1'b1, unprivileged_thread_bit)
    `CHK("frame pc", 32'h1234, u_mem.mem[7'h7e])
    `CHK("handler", 32'hc01, br)
    pc_write_ret_kind = 1'b0;
    do_ret(XSE_RET_THR_MAIN);
    pc_write_ret_kind = 1'b1;
    do_ret(32'hffff_fff5);
    `CHK("xn count", 3, xn)
    `CHK("mode", 1'b1, handler_mode)
    do_ret(XSE_RET_THR_MAIN);
    `CHK("number", 6'd0, exception_number_field)
    `CHK("main sp", 32'h0, main_stack_pointer)
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    t_entry_main();
    t_ret_proc();
    t_entry_proc();
    t_nested();
    t_ret_main();
    t_thread_code();
    t_fault_unpriv();
    finish_test();
  end
endmodule
